// ==== bench/breakpoint_unit_tb.sv ====
`timescale 1ns/1ps
`include "breakpoint_unit_regs.svh"
module breakpoint_unit_tb;
  import breakpoint_unit_pkg::*;
  typedef struct packed {
    logic [2:0]  amask;
    logic [5:0]  cc;
    logic        f;
    logic        w;
    logic [1:0]  sz;
    logic [31:0] a;
    logic [7:0]  id;
    logic        exp;
  } row_t;
  logic        sys_clk;
  logic        nrst;
  logic        standby;
  logic [7:0]  page_entry_high_id;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic        break_req;
  logic        break_after;
  bus_cycle_t  cycle;
  logic [31:0] v;
  int          num_errors;
  int          n_checks;
  row_t        rows[18] = '{
    '{3'h0, 6'h3F, 1'b0, 1'b0, 2'h3, 32'h12345678, 8'h5A, 1'b1},
    '{3'h0, 6'h3F, 1'b0, 1'b0, 2'h3, 32'h12345679, 8'h5A, 1'b0},
    '{3'h1, 6'h3F, 1'b0, 1'b0, 2'h3, 32'h123457FF, 8'h5A, 1'b1},
    '{3'h1, 6'h3F, 1'b0, 1'b0, 2'h3, 32'h12345800, 8'h5A, 1'b0},
    '{3'h2, 6'h3F, 1'b0, 1'b0, 2'h3, 32'h12345800, 8'h5A, 1'b1},
    '{3'h2, 6'h3F, 1'b0, 1'b0, 2'h3, 32'h12346000, 8'h5A, 1'b0},
    '{3'h3, 6'h3F, 1'b0, 1'b0, 2'h3, 32'hDEADBEEF, 8'h5A, 1'b1},
    '{3'h0, 6'h3F, 1'b0, 1'b0, 2'h3, 32'h12345678, 8'h5B, 1'b0},
    '{3'h4, 6'h3F, 1'b0, 1'b0, 2'h3, 32'h12345678, 8'h5B, 1'b1},
    '{3'h0, 6'h1F, 1'b0, 1'b0, 2'h3, 32'h12345678, 8'h5A, 1'b0},
    '{3'h0, 6'h1F, 1'b1, 1'b0, 2'h3, 32'h12345678, 8'h5A, 1'b1},
    '{3'h0, 6'h2F, 1'b1, 1'b0, 2'h3, 32'h12345678, 8'h5A, 1'b0},
    '{3'h0, 6'h00, 1'b0, 1'b0, 2'h3, 32'h12345678, 8'h5A, 1'b0},
    '{3'h0, 6'h37, 1'b0, 1'b1, 2'h3, 32'h12345678, 8'h5A, 1'b0},
    '{3'h0, 6'h3B, 1'b0, 1'b1, 2'h3, 32'h12345678, 8'h5A, 1'b1},
    '{3'h0, 6'h3D, 1'b0, 1'b0, 2'h3, 32'h12345678, 8'h5A, 1'b0},
    '{3'h0, 6'h3D, 1'b0, 1'b0, 2'h1, 32'h12345678, 8'h5A, 1'b1},
    '{3'h0, 6'h3E, 1'b0, 1'b0, 2'h2, 32'h12345678, 8'h5A, 1'b1}};

  breakpoint_unit dut_u (.sys_clk(sys_clk), .nrst(nrst), .standby(standby),
    .cycle(cycle), .page_entry_high_id(page_entry_high_id),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .break_req(break_req), .break_after(break_after));
  core_bus_model bus_u (.sys_clk(sys_clk), .cycle(cycle));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is taken one cycle after the strobe, when the pulse stands.
  task automatic rd(input logic [31:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, reg_rvalid}, 32'h1);
    v = reg_rdata;
  endtask
  task automatic rd_exp(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask
  task automatic hit(input logic f, input logic w, input logic [1:0] sz,
                     input logic [31:0] a, input logic [31:0] d,
                     input logic e);
    bus_u.issue(f, w, sz, a, d);
    #1;
    chk({31'h0, break_req}, {31'h0, e});
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    standby = 1'b0;
    page_entry_high_id = 8'h5A;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    #1 chk({30'h0, break_req, reg_rvalid}, 32'h0);
    rd_exp(`BPU_A_CCOND, 32'h0);
    rd_exp(`BPU_B_CCOND, 32'h0);
    rd_exp(`BPU_CTL, 32'h0);
    wr(`BPU_A_ADDR, 32'h12345678);
    wr(`BPU_A_ID, 32'h5A);
    foreach (rows[i]) begin
      wr(`BPU_A_AMASK, {29'h0, rows[i].amask});
      wr(`BPU_A_CCOND, {26'h0, rows[i].cc});
      wr(`BPU_CTL, 32'h0);
      page_entry_high_id <= rows[i].id;
      hit(rows[i].f, rows[i].w, rows[i].sz, rows[i].a, 32'h0, rows[i].exp);
      rd(`BPU_CTL);
      chk({31'h0, v[15]}, {31'h0, rows[i].exp});
    end
    hit(1'b0, 1'b0, 2'h2, 32'h12345678, 32'h0, 1'b0);
    wr(`BPU_A_AMASK, 32'h7);
    rd_exp(`BPU_A_AMASK, 32'h7);
    wr(`BPU_CTL, 32'hFFFF);
    rd_exp(`BPU_CTL, 32'hC4C8);
    rd_exp(32'h0FFFFFC0, 32'h0);
    wr(`BPU_A_AMASK, 32'h0);
    wr(`BPU_A_CCOND, 32'h1F);
    wr(`BPU_CTL, 32'h0400);
    bus_u.issue(1'b1, 1'b0, 2'h3, 32'h12345678, 32'h0);
    #1 chk({30'h0, break_req, break_after}, 32'h3);
    wr(`BPU_B_ADDR, 32'hA000);
    wr(`BPU_B_ID, 32'h5A);
    wr(`BPU_B_AMASK, 32'h4);
    wr(`BPU_B_CCOND, 32'h2C);
    wr(`BPU_A_CCOND, 32'h2F);
    wr(`BPU_CTL, 32'h0008);
    hit(1'b0, 1'b0, 2'h3, 32'hA000, 32'h0, 1'b0);
    hit(1'b0, 1'b0, 2'h3, 32'h12345678, 32'h0, 1'b0);
    hit(1'b0, 1'b0, 2'h3, 32'hA000, 32'h0, 1'b1);
    rd_exp(`BPU_CTL, 32'hC008);
    wr(`BPU_A_CCOND, 32'h0);
    wr(`BPU_B_DATA, 32'h11223344);
    wr(`BPU_B_DMASK, 32'hFF);
    wr(`BPU_CTL, 32'h0080);
    hit(1'b0, 1'b1, 2'h3, 32'hA000, 32'h112233AA, 1'b1);
    wr(`BPU_CTL, 32'h0080);
    hit(1'b0, 1'b1, 2'h3, 32'hA000, 32'h1122FF44, 1'b0);
    wr(`BPU_CTL, 32'h0);
    hit(1'b0, 1'b1, 2'h3, 32'hA000, 32'h1122FF44, 1'b1);
    wr(`BPU_B_DMASK, 32'h0);
    wr(`BPU_CTL, 32'h0080);
    hit(1'b0, 1'b1, 2'h1, 32'hA000, 32'h99999944, 1'b1);
    wr(`BPU_CTL, 32'h0);
    standby <= 1'b1;
    hit(1'b0, 1'b1, 2'h3, 32'hA000, 32'h0, 1'b0);
    @(posedge sys_clk);
    standby <= 1'b0;
    rd_exp(`BPU_B_ADDR, 32'hA000);
    // A reset in mid-run clears control state but keeps the comparands.
    wr(`BPU_CTL, 32'h0088);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1 chk({30'h0, break_req, reg_rvalid}, 32'h0);
    rd_exp(`BPU_CTL, 32'h0);
    rd_exp(`BPU_B_CCOND, 32'h0);
    rd_exp(`BPU_B_ADDR, 32'hA000);
    report_and_stop();
  end
endmodule

// ==== bench/core_bus_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Processor core bus model
// ****************************************************************
module core_bus_model
  import breakpoint_unit_pkg::*;
(
  input  wire logic                            sys_clk,
  output breakpoint_unit_pkg::bus_cycle_t      cycle
);
  initial cycle = '0;

  // One bus cycle per call. Between cycles every field is inverted so that a
  // matcher which ignores the valid bit cannot hit on stale values.
  task automatic issue(input logic f, input logic w, input logic [1:0] sz,
                       input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cycle <= {1'b1, f, w, sz, a, d};
    @(posedge sys_clk);
    cycle <= {1'b0, ~f, ~w, ~sz, ~a, ~d};
  endtask
endmodule

// ==== core/breakpoint_unit.sv ====
`timescale 1ns/1ps
`include "breakpoint_unit_regs.svh"
module breakpoint_unit
  import breakpoint_unit_pkg::*;
(
  input  wire logic                           sys_clk,
  input  wire logic                           nrst,
  input  wire logic                           standby,
  input  wire breakpoint_unit_pkg::bus_cycle_t cycle,
  input  wire logic [7:0]                     page_entry_high_id,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  input  wire logic [31:0]                    reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  output logic [31:0]                         reg_rdata,
  output logic                                reg_rvalid,
  output logic                                break_req,
  output logic                                break_after
);
  import breakpoint_unit_pkg::*;

  bpu_state_t st;
  bpu_state_t next_st;
  logic       hit_a;
  logic       hit_b;
  logic       chain;
  logic       fire_a;
  logic       fire_b;

  // ****************************************************************
  // Match functions
  // ****************************************************************
  // A field of 00 is treated as "any" for direction and size; for the
  // cycle type it disables the channel so a reset unit never traps.
  function automatic logic sel_ok(input logic [1:0] sel,
                                  input logic       lo,
                                  input logic       hi);
    sel_ok = (sel[0] & lo) | (sel[1] & hi);
  endfunction

  function automatic logic chan_hit(input chan_cfg_t  c,
                                    input bus_cycle_t  cy,
                                    input logic [7:0]  cur_id);
    logic [31:0] m;
    logic        size_ok;
    m = 32'hFFFFFFFF;
    case (c.amask[`BPU_AMASK_SEL])
      2'b01: m = `BPU_LOW10;
      2'b10: m = `BPU_LOW12;
      2'b11: m = 32'h00000000;
      default: m = 32'hFFFFFFFF;
    endcase
    size_ok = (c.ccond[`BPU_CC_SIZE] == 2'b00) ||
              (c.ccond[`BPU_CC_SIZE] == cy.size);
    chan_hit = cy.valid &&
      sel_ok(c.ccond[`BPU_CC_TYPE], cy.fetch, !cy.fetch) &&
      ((c.ccond[`BPU_CC_DIR] == 2'b00) ||
       sel_ok(c.ccond[`BPU_CC_DIR], !cy.write, cy.write)) &&
      size_ok &&
      (((cy.addr ^ c.addr) & m) == 32'h00000000) &&
      (c.amask[`BPU_ID_MASK_BIT] || (c.space_id == cur_id));
  endfunction

  function automatic logic data_hit(input logic [31:0] val,
                                    input logic [31:0] cmpv,
                                    input logic [31:0] dm,
                                    input logic [1:0]  size);
    logic [31:0] lanes;
    lanes = 32'hFFFFFFFF;
    if (size == 2'b01) begin
      lanes = `BPU_BYTE_LANES;
    end else if (size == 2'b10) begin
      lanes = `BPU_WORD_LANES;
    end
    // Set mask bits exclude that bit from the comparison.
    data_hit = (((val ^ cmpv) & ~dm & lanes) == 32'h00000000);
  endfunction

  // ****************************************************************
  // Comparison
  // ****************************************************************
  always_comb begin
    chain = st.ctl[`BPU_CTL_CHAIN];
    // Channel B uses the same compare as channel A, plus the data compare on non-fetch cycles when BPU_CTL_DATA_EN_B is set.
    hit_a = chan_hit(st.a, cycle, page_entry_high_id) && !standby;
    hit_b = chan_hit(st.b, cycle, page_entry_high_id) && !standby &&
            (!st.ctl[`BPU_CTL_DATA_EN_B] || cycle.fetch ||
             data_hit(cycle.data, st.cmp_data, st.data_mask,
                      cycle.size));
    // Flags must be cleared before a channel can trap again.
    fire_a = hit_a && !chain && !st.ctl[`BPU_CTL_FLAG_A];
    fire_b = hit_b && !st.ctl[`BPU_CTL_FLAG_B] &&
             (!chain || st.ctl[`BPU_CTL_FLAG_A]);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.rvalid = reg_rd;
    next_st.brk = fire_a || fire_b;
    next_st.brk_after = (fire_a && cycle.fetch &&
                         st.ctl[`BPU_CTL_AFTER_A]) ||
                        (fire_b && cycle.fetch &&
                         st.ctl[`BPU_CTL_AFTER_B]);
    if (reg_rd) begin
      if (reg_addr == `BPU_A_ADDR) begin
        next_st.rdata = st.a.addr;
      end else if (reg_addr == `BPU_B_ADDR) begin
        next_st.rdata = st.b.addr;
      end else if (reg_addr == `BPU_A_ID) begin
        next_st.rdata = {24'h000000, st.a.space_id};
      end else if (reg_addr == `BPU_B_ID) begin
        next_st.rdata = {24'h000000, st.b.space_id};
      end else if (reg_addr == `BPU_A_AMASK) begin
        next_st.rdata = {29'h00000000, st.a.amask};
      end else if (reg_addr == `BPU_B_AMASK) begin
        next_st.rdata = {29'h00000000, st.b.amask};
      end else if (reg_addr == `BPU_A_CCOND) begin
        next_st.rdata = {16'h0000, st.a.ccond};
      end else if (reg_addr == `BPU_B_CCOND) begin
        next_st.rdata = {16'h0000, st.b.ccond};
      end else if (reg_addr == `BPU_B_DATA) begin
        next_st.rdata = st.cmp_data;
      end else if (reg_addr == `BPU_B_DMASK) begin
        next_st.rdata = st.data_mask;
      end else if (reg_addr == `BPU_CTL) begin
        next_st.rdata = {16'h0000, st.ctl};
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end
    if (reg_wr) begin
      if (reg_addr == `BPU_A_ADDR) begin
        next_st.a.addr = reg_wdata;
      end else if (reg_addr == `BPU_B_ADDR) begin
        next_st.b.addr = reg_wdata;
      end else if (reg_addr == `BPU_A_ID) begin
        next_st.a.space_id = reg_wdata[7:0];
      end else if (reg_addr == `BPU_B_ID) begin
        next_st.b.space_id = reg_wdata[7:0];
      end else if (reg_addr == `BPU_A_AMASK) begin
        next_st.a.amask = reg_wdata[2:0];
      end else if (reg_addr == `BPU_B_AMASK) begin
        next_st.b.amask = reg_wdata[2:0];
      end else if (reg_addr == `BPU_A_CCOND) begin
        next_st.a.ccond = reg_wdata[15:0] & `BPU_CC_WMASK;
      end else if (reg_addr == `BPU_B_CCOND) begin
        next_st.b.ccond = reg_wdata[15:0] & `BPU_CC_WMASK;
      end else if (reg_addr == `BPU_B_DATA) begin
        next_st.cmp_data = reg_wdata;
      end else if (reg_addr == `BPU_B_DMASK) begin
        next_st.data_mask = reg_wdata;
      end else if (reg_addr == `BPU_CTL) begin
        next_st.ctl = reg_wdata[15:0] & `BPU_CTL_WMASK;
      end
    end
    // Hardware set is applied last but only to a clear flag, so a same-cycle clear of a set flag still wins.
    if (hit_a && !st.ctl[`BPU_CTL_FLAG_A]) begin
      next_st.ctl[`BPU_CTL_FLAG_A] = 1'b1;
    end
    if (fire_b) begin
      next_st.ctl[`BPU_CTL_FLAG_B] = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Standby only masks the matches; register writes, read data and the break outputs still update.
  always_ff @(posedge sys_clk) begin
    st <= next_st;
    if (!nrst) begin
      st.a.ccond <= `BPU_CC_RESET;
      st.b.ccond <= `BPU_CC_RESET;
      st.ctl     <= `BPU_CTL_RESET;
      st.rvalid  <= 1'b0;
      st.rdata   <= 32'h00000000;
      st.brk     <= 1'b0;
      st.brk_after <= 1'b0;
    end
  end

  assign reg_rdata   = st.rdata;
  assign reg_rvalid  = st.rvalid;
  assign break_req   = st.brk;
  assign break_after = st.brk_after;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_chain_order;
    @(posedge sys_clk) disable iff (!nrst)
    chain && hit_b && !st.ctl[`BPU_CTL_FLAG_A] && !hit_a |=> !break_req;
  endproperty
  a_chain_order: assert property (p_chain_order)
    else $error("chained break without prior channel A match");

  property p_chain_a_alone;
    @(posedge sys_clk) disable iff (!nrst)
    chain && hit_a && !hit_b |=> !break_req && st.ctl[`BPU_CTL_FLAG_A];
  endproperty
  a_chain_a_alone: assert property (p_chain_a_alone)
    else $error("channel A alone raised a chained break");

  property p_indep_break;
    @(posedge sys_clk) disable iff (!nrst)
    !chain && hit_a && !st.ctl[`BPU_CTL_FLAG_A] |=> break_req;
  endproperty
  a_indep_break: assert property (p_indep_break)
    else $error("independent channel A match gave no break");

  property p_flag_set;
    @(posedge sys_clk) disable iff (!nrst)
    fire_b |=> st.ctl[`BPU_CTL_FLAG_B] && break_req;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("channel B flag not set on break");

  property p_reset_clear;
    @(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |-> st.ctl == `BPU_CTL_RESET &&
                    st.a.ccond == `BPU_CC_RESET &&
                    st.b.ccond == `BPU_CC_RESET && !break_req;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control state not cleared by reset");

  property p_mask_reserved;
    @(posedge sys_clk) disable iff (!nrst)
    reg_rd && (reg_addr == `BPU_A_AMASK || reg_addr == `BPU_B_AMASK)
      |=> reg_rvalid && reg_rdata[31:3] == 29'h00000000;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved)
    else $error("address mask reserved bits read nonzero");

  property p_disabled_quiet;
    @(posedge sys_clk) disable iff (!nrst)
    st.a.ccond[`BPU_CC_TYPE] == 2'b00 &&
    st.b.ccond[`BPU_CC_TYPE] == 2'b00 |=> !break_req;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("break with both channels disabled");

  property p_after_is_fetch;
    @(posedge sys_clk) disable iff (!nrst)
    break_after |-> break_req && $past(cycle.fetch);
  endproperty
  a_after_is_fetch: assert property (p_after_is_fetch)
    else $error("after-execution break not from a fetch");

  property p_standby_hold;
    @(posedge sys_clk) disable iff (!nrst)
    standby && !reg_wr |=> $stable(st.a) && $stable(st.b) && !break_req;
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("registers changed in standby");

  property p_flag_a_set;
    @(posedge sys_clk) disable iff (!nrst)
    hit_a && !st.ctl[`BPU_CTL_FLAG_A] |=> st.ctl[`BPU_CTL_FLAG_A];
  endproperty
  a_flag_a_set: assert property (p_flag_a_set)
    else $error("channel A flag not set on match");

  // Only a software write may drop a flag; a lost flag would rearm a trap.
  property p_flag_a_hold;
    @(posedge sys_clk) disable iff (!nrst)
    st.ctl[`BPU_CTL_FLAG_A] && !(reg_wr && reg_addr == `BPU_CTL)
      |=> st.ctl[`BPU_CTL_FLAG_A];
  endproperty
  a_flag_a_hold: assert property (p_flag_a_hold)
    else $error("channel A flag dropped without a write");

  c_chain_break: cover property (@(posedge sys_clk) disable iff (!nrst)
    chain && fire_b ##1 break_req);
  c_indep_break: cover property (@(posedge sys_clk) disable iff (!nrst)
    !chain && fire_a ##1 break_req);
  c_after_break: cover property (@(posedge sys_clk) disable iff (!nrst)
    break_after);
  c_data_break: cover property (@(posedge sys_clk) disable iff (!nrst)
    !chain && fire_b && st.ctl[`BPU_CTL_DATA_EN_B] ##1 break_req);
  c_chain_arm: cover property (@(posedge sys_clk) disable iff (!nrst)
    chain && hit_a && !st.ctl[`BPU_CTL_FLAG_A]);
endmodule

// ==== inc/breakpoint_unit_pkg.sv ====
package breakpoint_unit_pkg;
  // Bus cycle seen by the unit; size 01 byte, 10 word, 11 longword.
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] data;
  } bus_cycle_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  space_id;
    logic [2:0]  amask;
    logic [15:0] ccond;
  } chan_cfg_t;

  typedef struct packed {
    chan_cfg_t   a;
    chan_cfg_t   b;
    logic [31:0] cmp_data;
    logic [31:0] data_mask;
    logic [15:0] ctl;
    logic [31:0] rdata;
    logic        rvalid;
    logic        brk;
    logic        brk_after;
  } bpu_state_t;
endpackage

// ==== inc/breakpoint_unit_regs.svh ====
`ifndef BREAKPOINT_UNIT_REGS_SVH
`define BREAKPOINT_UNIT_REGS_SVH
// ****************************************************************
// Register addresses
// ****************************************************************
`define BPU_B_ADDR     32'h0FFFFFA0
`define BPU_B_AMASK    32'h0FFFFFA4
`define BPU_B_CCOND    32'h0FFFFFA8
`define BPU_A_ADDR     32'h0FFFFFB0
`define BPU_A_AMASK    32'h0FFFFFB4
`define BPU_A_CCOND    32'h0FFFFFB8
`define BPU_A_ID       32'h0FFFFFE4
`define BPU_B_ID       32'h0FFFFFE8
`define BPU_B_DATA     32'hFFFFFF90
`define BPU_B_DMASK    32'hFFFFFF94
`define BPU_CTL        32'hFFFFFF98
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define BPU_ID_MASK_BIT   2
`define BPU_AMASK_SEL     1:0
`define BPU_CC_TYPE       5:4
`define BPU_CC_DIR        3:2
`define BPU_CC_SIZE       1:0
`define BPU_CTL_FLAG_A    15
`define BPU_CTL_FLAG_B    14
`define BPU_CTL_AFTER_A   10
`define BPU_CTL_DATA_EN_B 7
`define BPU_CTL_AFTER_B   6
`define BPU_CTL_CHAIN     3
`define BPU_CTL_WMASK     16'hC4C8
`define BPU_CC_WMASK      16'h003F
`define BPU_CC_RESET      16'h0000
`define BPU_CTL_RESET     16'h0000
`define BPU_LOW10         32'hFFFFFC00
`define BPU_LOW12         32'hFFFFF000
`define BPU_BYTE_LANES    32'h000000FF
`define BPU_WORD_LANES    32'h0000FFFF
`endif
